/* File: hw/fidst_top.v */
`timescale 1ns/100ps
`include "fidst_consts.vh"

// Operation
// - accumulator group: fixed word, code bits 13-14
// - group codes: convert, negate, convert ext, back
// - dual group: opcode word, then mode word
// - mode 0 reg, 1 ind, 2 sym/idx, 3 auto
// - autoincrement by 4, multiply-wide destination 8
// - compare sets status only, stores nothing
// - multiply-wide writes four destination words
// - bit 0 nonzero result, multiply-wide clears
// - bit 1 positive nonzero, compare greater, mmw clear
// - bit 2 zero result, compare equal
// - bit 3 carry per instruction class
// - bit 4 fault per instruction class
// - bits 5-15 untouched by float instructions
// - accumulator is workspace registers 0 and 1
// - real: sign, 7-bit radix-16 exponent, bias 64
module fidst_top #(
  parameter AW = 6
) (
  input  wire          REF_CLK,
  input  wire          RST,
  input  wire [AW-1:0] AVS_ADDRESS,
  input  wire          AVS_READ,
  input  wire          AVS_WRITE,
  input  wire [31:0]   AVS_WRITEDATA,
  input  wire [3:0]    AVS_BYTEENABLE,
  output reg  [31:0]   AVS_READDATA,
  output wire          AVS_WAITREQUEST,
  output wire          IRQ,
  output reg           DEC_VALID,
  output reg  [3:0]    DEC_OP,
  output reg  [2:0]    DEC_SRC_KIND,
  output reg  [3:0]    DEC_SRC_REG,
  output reg  [3:0]    DEC_SRC_INC,
  output reg  [2:0]    DEC_DST_KIND,
  output reg  [3:0]    DEC_DST_REG,
  output reg  [3:0]    DEC_DST_INC,
  output reg           DEC_ACC_WRITE,
  output reg           DEC_SRC_STORE,
  output reg  [2:0]    DEC_DST_WORDS,
  output wire [15:0]   STATUS_WORD
);

  // byte-lane merge of a write into a 32-bit register
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0]  be;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[i*8 +: 8] = be[i] ? wdata[i*8 +: 8]
                                     : old[i*8 +: 8];
      end
    end
  endfunction

  reg  [15:0]   instr0;
  reg  [15:0]   instr1;
  reg  [31:0]   res_word;
  reg  [31:0]   res_ext;
  reg  [4:0]    cond;
  reg  [15:0]   st;
  reg  [2:0]    ev;
  reg  [2:0]    mask;
  reg           ack;
  reg  [31:0]   rd_mux;
  reg  [3:0]    op;
  reg  [15:0]   next_st;
  reg  [1:0]    src_mode;
  reg  [3:0]    src_reg;
  reg           uses_src;
  reg           uses_dst;
  wire          req;
  wire          wr_ok;
  wire [AW-1:0] addr;
  wire          go;
  wire [2:0]    src_kind;
  wire [3:0]    src_inc;
  wire          src_rsv;
  wire [2:0]    dst_kind;
  wire [3:0]    dst_inc;
  wire          dst_rsv;
  wire          is_acc;
  wire          is_dual;
  wire          is_srco;
  wire          bad_rsv;
  wire          legal;
  wire [2:0]    ev_set;
  wire [2:0]    ev_clr;
  wire          res_nz;
  wire          mmw_nz;
  wire          res_msb;
  wire [7:0]    exp_unb;

  // avalon slave: every access waits exactly one cycle
  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign wr_ok           = AVS_WRITE & ack;
  assign addr            = {AVS_ADDRESS[AW-1:2], 2'b00};

  always @(posedge REF_CLK) begin
    if (RST) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // go strobe comes from the command register, bit 0
  assign go = wr_ok && (addr == `FIDST_OFS_CMD) &&
              AVS_BYTEENABLE[0] && AVS_WRITEDATA[`FIDST_CMD_GO];

  // group recognition on the first word, plus word two's top nibble for dual
  assign is_acc  = (instr0 & `FIDST_ACC_MASK) == `FIDST_ACC_PAT;
  assign is_dual = ((instr0 & `FIDST_DUAL_MASK) ==
                    `FIDST_DUAL_PAT) &&
                   (instr1[15:12] == `FIDST_NIB_ZERO);
  assign is_srco = (instr0[15:12] == `FIDST_NIB_ZERO);

  // operation identifier from whichever group matched
  always @* begin
    op = `FIDST_OP_NONE;
    if (is_acc) begin
      case (instr0[2:1])
        `FIDST_ACC_R2I: op = `FIDST_OP_R2I;
        `FIDST_ACC_NEG: op = `FIDST_OP_NEG;
        `FIDST_ACC_R2E: op = `FIDST_OP_R2E;
        `FIDST_ACC_E2R: op = `FIDST_OP_E2R;
        default:        op = `FIDST_OP_NONE;
      endcase
    end else if (is_dual) begin
      case (instr0[3:0])
        `FIDST_DOP_CMP: op = `FIDST_OP_CMP;
        `FIDST_DOP_MMW: op = `FIDST_OP_MMW;
        default:        op = `FIDST_OP_NONE;
      endcase
    end else if (is_srco) begin
      // source-only group is decoded for status updates
      case (instr0[11:6])
        `FIDST_SOP_ADD: op = `FIDST_OP_ADD;
        `FIDST_SOP_SUB: op = `FIDST_OP_SUB;
        `FIDST_SOP_MUL: op = `FIDST_OP_MUL;
        `FIDST_SOP_DIV: op = `FIDST_OP_DIV;
        `FIDST_SOP_LD:  op = `FIDST_OP_LD;
        `FIDST_SOP_ST:  op = `FIDST_OP_ST;
        `FIDST_SOP_I2R: op = `FIDST_OP_I2R;
        default:        op = `FIDST_OP_NONE;
      endcase
    end
  end

  // source field sits in word two for dual ops, word one else
  always @* begin
    src_mode = instr0[5:4];
    src_reg  = instr0[3:0];
    uses_src = 1'b0;
    uses_dst = 1'b0;
    if (op == `FIDST_OP_CMP || op == `FIDST_OP_MMW) begin
      src_mode = instr1[5:4];
      src_reg  = instr1[3:0];
      uses_src = 1'b1;
      uses_dst = 1'b1;
    end else if (op >= `FIDST_OP_ADD) begin
      uses_src = 1'b1;
    end
  end

  fidst_mode_dec u_src (
    .MODE     (src_mode),
    .REG_NUM  (src_reg),
    .WIDE     (1'b0),
    .KIND     (src_kind),
    .INC      (src_inc),
    .RESERVED (src_rsv)
  );

  fidst_mode_dec u_dst (
    .MODE     (instr1[11:10]),
    .REG_NUM  (instr1[9:6]),
    .WIDE     (op == `FIDST_OP_MMW),
    .KIND     (dst_kind),
    .INC      (dst_inc),
    .RESERVED (dst_rsv)
  );

  // reserved r0 encodings are refused rather than guessed at
  assign bad_rsv = (uses_src & src_rsv) | (uses_dst & dst_rsv);
  assign legal   = (op != `FIDST_OP_NONE) & ~bad_rsv;

  // result tests; real value in res_word, mmw high half in res_ext
  assign res_nz  = |res_word;
  assign mmw_nz  = (|res_word) | (|res_ext);
  assign res_msb = res_word[31];
  assign exp_unb = {1'b0, res_word[30:24]} - `FIDST_EXP_BIAS;

  // status update; low bits 10:0 always carried through
  always @* begin
    next_st = st;
    case (op)
      `FIDST_OP_MMW: begin
        next_st[`FIDST_ST_LGT]   = 1'b0;
        next_st[`FIDST_ST_AGT]   = 1'b0;
        next_st[`FIDST_ST_EQ]    = ~mmw_nz;
        next_st[`FIDST_ST_CARRY] = 1'b0;
        next_st[`FIDST_ST_FAULT] = 1'b0;
      end
      `FIDST_OP_CMP: begin
        // compare result is source minus destination
        next_st[`FIDST_ST_LGT]   = ~cond[`FIDST_C_EQ];
        next_st[`FIDST_ST_AGT]   = cond[`FIDST_C_GT];
        next_st[`FIDST_ST_EQ]    = cond[`FIDST_C_EQ];
        next_st[`FIDST_ST_CARRY] = 1'b0;
        next_st[`FIDST_ST_FAULT] = 1'b0;
      end
      default: begin
        next_st[`FIDST_ST_LGT] = res_nz;
        next_st[`FIDST_ST_AGT] = ~res_msb & res_nz;
        next_st[`FIDST_ST_EQ]  = ~res_nz;
      end
    endcase
    case (op)
      `FIDST_OP_ADD, `FIDST_OP_SUB,
      `FIDST_OP_MUL, `FIDST_OP_DIV: begin
        next_st[`FIDST_ST_CARRY] = cond[`FIDST_C_OVF];
        next_st[`FIDST_ST_FAULT] = cond[`FIDST_C_OVF] |
                                   cond[`FIDST_C_UNF];
      end
      `FIDST_OP_I2R, `FIDST_OP_E2R: begin
        next_st[`FIDST_ST_CARRY] = 1'b1;
        next_st[`FIDST_ST_FAULT] = 1'b0;
      end
      `FIDST_OP_R2I, `FIDST_OP_R2E: begin
        next_st[`FIDST_ST_CARRY] = cond[`FIDST_C_UNREP];
        next_st[`FIDST_ST_FAULT] = cond[`FIDST_C_UNREP];
      end
      default: begin
        // load, store and negate leave carry and fault alone
        next_st[`FIDST_ST_CARRY] = next_st[`FIDST_ST_CARRY];
      end
    endcase
  end

  // software-visible registers and the status word
  always @(posedge REF_CLK) begin
    if (RST) begin
      instr0   <= 16'h0000;
      instr1   <= 16'h0000;
      res_word <= 32'h0000_0000;
      res_ext  <= 32'h0000_0000;
      cond     <= `FIDST_RST_COND;
      st       <= `FIDST_RST_STATUS;
      mask     <= `FIDST_RST_MASK;
    end else begin
      if (wr_ok) begin
        case (addr)
          `FIDST_OFS_INSTR0:
            instr0 <= {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : instr0[15:8],
                       AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : instr0[7:0]};
          `FIDST_OFS_INSTR1:
            instr1 <= {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : instr1[15:8],
                       AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : instr1[7:0]};
          `FIDST_OFS_RESULT:
            res_word <= lane_merge(res_word, AVS_WRITEDATA,
                                   AVS_BYTEENABLE);
          `FIDST_OFS_RESEXT:
            res_ext <= lane_merge(res_ext, AVS_WRITEDATA,
                                  AVS_BYTEENABLE);
          `FIDST_OFS_COND: begin
            if (AVS_BYTEENABLE[0]) begin
              cond <= AVS_WRITEDATA[4:0];
            end
          end
          `FIDST_OFS_STATUS:
            st <= {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : st[15:8],
                   AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : st[7:0]};
          `FIDST_OFS_MASK: begin
            if (AVS_BYTEENABLE[0]) begin
              mask <= AVS_WRITEDATA[2:0];
            end
          end
          default: begin
            mask <= mask; // unmapped writes are dropped
          end
        endcase
      end
      // go never coincides with a status write: one access a cycle
      if (go && legal) begin
        st <= next_st;
      end
    end
  end

  // sticky events; a new event beats a same-cycle clear
  assign ev_set[`FIDST_E_DONE] = go & legal;
  assign ev_set[`FIDST_E_ILL]  = go & (op == `FIDST_OP_NONE);
  assign ev_set[`FIDST_E_RSV]  = go & (op != `FIDST_OP_NONE) & bad_rsv;
  assign ev_clr = (wr_ok && addr == `FIDST_OFS_EVENT &&
                   AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[2:0] : 3'h0;

  always @(posedge REF_CLK) begin
    if (RST) begin
      ev <= 3'h0;
    end else begin
      ev <= (ev & ~ev_clr) | ev_set;
    end
  end

  assign IRQ         = |(ev & mask);
  assign STATUS_WORD = st;

  // decoded operation towards the sequencer, held until the next legal go
  always @(posedge REF_CLK) begin
    if (RST) begin
      DEC_VALID     <= 1'b0;
      DEC_OP        <= `FIDST_OP_NONE;
      DEC_SRC_KIND  <= `FIDST_K_REG;
      DEC_SRC_REG   <= 4'h0;
      DEC_SRC_INC   <= `FIDST_INC_NONE;
      DEC_DST_KIND  <= `FIDST_K_REG;
      DEC_DST_REG   <= 4'h0;
      DEC_DST_INC   <= `FIDST_INC_NONE;
      DEC_ACC_WRITE <= 1'b0;
      DEC_SRC_STORE <= 1'b0;
      DEC_DST_WORDS <= `FIDST_NO_WORDS;
    end else begin
      DEC_VALID <= go & legal;
      if (go && legal) begin
        DEC_OP <= op;
        // accumulator ops work on r0/r1 directly
        DEC_SRC_KIND <= uses_src ? src_kind : `FIDST_K_REG;
        DEC_SRC_REG  <= uses_src ? src_reg : `FIDST_ACC_REG;
        DEC_SRC_INC  <= uses_src ? src_inc : `FIDST_INC_NONE;
        DEC_DST_KIND <= uses_dst ? dst_kind : `FIDST_K_REG;
        DEC_DST_REG  <= uses_dst ? instr1[9:6] : `FIDST_ACC_REG;
        DEC_DST_INC  <= uses_dst ? dst_inc : `FIDST_INC_NONE;
        // everything but compare, mmw and store lands in r0/r1
        DEC_ACC_WRITE <= (op != `FIDST_OP_CMP) &&
                         (op != `FIDST_OP_MMW) &&
                         (op != `FIDST_OP_ST);
        DEC_SRC_STORE <= (op == `FIDST_OP_ST);
        // compare writes nothing; mmw writes 64 bits at da+0..6
        DEC_DST_WORDS <= (op == `FIDST_OP_MMW) ?
                         `FIDST_MMW_WORDS : `FIDST_NO_WORDS;
      end
    end
  end

  // read mux; info shows sign, unbiased exponent, lead digit
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `FIDST_OFS_INSTR0: rd_mux = {16'h0000, instr0};
      `FIDST_OFS_INSTR1: rd_mux = {16'h0000, instr1};
      `FIDST_OFS_RESULT: rd_mux = res_word;
      `FIDST_OFS_RESEXT: rd_mux = res_ext;
      `FIDST_OFS_COND:   rd_mux = {27'h0, cond};
      `FIDST_OFS_CMD:    rd_mux = {27'h0, legal, op};
      `FIDST_OFS_STATUS: rd_mux = {16'h0000, st};
      `FIDST_OFS_INFO:
        rd_mux = {16'h0000, res_word[31], 3'h0,
                  res_word[23:20], exp_unb};
      `FIDST_OFS_EVENT:  rd_mux = {29'h0, ev};
      `FIDST_OFS_MASK:   rd_mux = {29'h0, mask};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, valid when wait drops
  always @(posedge REF_CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= rd_mux;
    end
  end

endmodule

/* File: hw/fidst_consts.vh */
`ifndef FIDST_CONSTS_VH
`define FIDST_CONSTS_VH

// register byte offsets on the avalon slave
`define FIDST_OFS_INSTR0 6'h00
`define FIDST_OFS_INSTR1 6'h04
`define FIDST_OFS_RESULT 6'h08
`define FIDST_OFS_RESEXT 6'h0c
`define FIDST_OFS_COND   6'h10
`define FIDST_OFS_CMD    6'h14
`define FIDST_OFS_STATUS 6'h18
`define FIDST_OFS_INFO   6'h1c
`define FIDST_OFS_EVENT  6'h20
`define FIDST_OFS_MASK   6'h24

// condition register bit positions
`define FIDST_C_OVF   0
`define FIDST_C_UNF   1
`define FIDST_C_UNREP 2
`define FIDST_C_GT    3
`define FIDST_C_EQ    4

// event and mask bit positions
`define FIDST_E_DONE 0
`define FIDST_E_ILL  1
`define FIDST_E_RSV  2
`define FIDST_CMD_GO 0

// reset values
`define FIDST_RST_STATUS 16'h0000
`define FIDST_RST_MASK   3'h0
`define FIDST_RST_COND   5'h00

// instruction word patterns, msb-first bit 0 is verilog bit 15
`define FIDST_ACC_PAT   16'h0c00
`define FIDST_ACC_MASK  16'hfff9
`define FIDST_DUAL_PAT  16'h0300
`define FIDST_DUAL_MASK 16'hfff0
`define FIDST_NIB_ZERO  4'h0

// status bit positions (bit n of the status word is verilog 15-n)
`define FIDST_ST_LGT   15
`define FIDST_ST_AGT   14
`define FIDST_ST_EQ    13
`define FIDST_ST_CARRY 12
`define FIDST_ST_FAULT 11

// operand mode codes and decoded kinds
`define FIDST_MD_REG  2'h0
`define FIDST_MD_IND  2'h1
`define FIDST_MD_IDX  2'h2
`define FIDST_MD_AUTO 2'h3
`define FIDST_K_REG  3'h0
`define FIDST_K_IND  3'h1
`define FIDST_K_SYM  3'h2
`define FIDST_K_IDX  3'h3
`define FIDST_K_AUTO 3'h4
`define FIDST_INC_NORM 4'h4
`define FIDST_INC_WIDE 4'h8
`define FIDST_INC_NONE 4'h0

// group codes
`define FIDST_ACC_R2I 2'h0
`define FIDST_ACC_NEG 2'h1
`define FIDST_ACC_R2E 2'h2
`define FIDST_ACC_E2R 2'h3
`define FIDST_DOP_CMP 4'h1
`define FIDST_DOP_MMW 4'h2
`define FIDST_SOP_ADD 6'h31
`define FIDST_SOP_I2R 6'h32
`define FIDST_SOP_SUB 6'h33
`define FIDST_SOP_MUL 6'h34
`define FIDST_SOP_DIV 6'h35
`define FIDST_SOP_LD  6'h36
`define FIDST_SOP_ST  6'h37

// internal operation identifiers
`define FIDST_OP_NONE 4'h0
`define FIDST_OP_R2I  4'h1
`define FIDST_OP_NEG  4'h2
`define FIDST_OP_R2E  4'h3
`define FIDST_OP_E2R  4'h4
`define FIDST_OP_CMP  4'h5
`define FIDST_OP_MMW  4'h6
`define FIDST_OP_ADD  4'h7
`define FIDST_OP_SUB  4'h8
`define FIDST_OP_MUL  4'h9
`define FIDST_OP_DIV  4'ha
`define FIDST_OP_LD   4'hb
`define FIDST_OP_ST   4'hc
`define FIDST_OP_I2R  4'hd

// real format and write widths
`define FIDST_EXP_BIAS  8'h40
`define FIDST_MMW_WORDS 3'h4
`define FIDST_NO_WORDS  3'h0
`define FIDST_ACC_REG   4'h0

`endif

/* File: hw/fidst_mode_dec.v */
`timescale 1ns/100ps
`include "fidst_consts.vh"

module fidst_mode_dec (
  input  wire [1:0] MODE,
  input  wire [3:0] REG_NUM,
  input  wire       WIDE,
  output reg  [2:0] KIND,
  output reg  [3:0] INC,
  output reg        RESERVED
);

  // mode field plus register field to addressing kind
  always @* begin
    KIND     = `FIDST_K_REG;
    INC      = `FIDST_INC_NONE;
    RESERVED = 1'b0;
    case (MODE)
      `FIDST_MD_REG: begin
        KIND = `FIDST_K_REG;
      end
      `FIDST_MD_IND: begin
        KIND = `FIDST_K_IND;
      end
      `FIDST_MD_IDX: begin
        // zero register selects symbolic, never indexed off r0
        KIND = (REG_NUM == 4'h0) ? `FIDST_K_SYM : `FIDST_K_IDX;
      end
      `FIDST_MD_AUTO: begin
        KIND     = `FIDST_K_AUTO;
        INC      = WIDE ? `FIDST_INC_WIDE : `FIDST_INC_NORM;
        // r0 autoincrement has no defined meaning
        RESERVED = (REG_NUM == 4'h0);
      end
      default: begin
        KIND = `FIDST_K_REG;
      end
    endcase
  end

endmodule

/* File: bench/fidst_top_asserts.sv */
`timescale 1ns/100ps
`include "fidst_consts.vh"

// decode and status checks, seen from the top ports only
module fidst_chk #(
  parameter AW = 6
) (
  input logic          REF_CLK,
  input logic          RST,
  input logic [AW-1:0] AVS_ADDRESS,
  input logic          AVS_READ,
  input logic          AVS_WRITE,
  input logic [31:0]   AVS_WRITEDATA,
  input logic          AVS_WAITREQUEST,
  input logic          DEC_VALID,
  input logic [3:0]    DEC_OP,
  input logic [2:0]    DEC_SRC_KIND,
  input logic [3:0]    DEC_SRC_REG,
  input logic [3:0]    DEC_SRC_INC,
  input logic [2:0]    DEC_DST_KIND,
  input logic [3:0]    DEC_DST_INC,
  input logic          DEC_ACC_WRITE,
  input logic [2:0]    DEC_DST_WORDS,
  input logic [15:0]   STATUS_WORD
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // accepted go write, and the pulse of a wide multiply
  sequence go_take;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == `FIDST_OFS_CMD
      && AVS_WRITEDATA[`FIDST_CMD_GO];
  endsequence
  sequence mmw_done;
    DEC_VALID && DEC_OP == `FIDST_OP_MMW;
  endsequence

  // bus answers after one wait cycle, pulse only after an ack
  one_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("wait cycle count wrong");
  pulse_once_a: assert property (DEC_VALID |-> $past(AVS_WRITE)
    && $past(!AVS_WAITREQUEST) ##1 !DEC_VALID) else $error("bad pulse");
  // a refused go must not disturb the flags
  refused_keep_a: assert property (go_take ##1 !DEC_VALID
    |-> $stable(STATUS_WORD)) else $error("refused go changed status");
  high_bits_a: assert property (
    DEC_VALID |-> STATUS_WORD[10:0] == $past(STATUS_WORD[10:0]))
    else $error("upper status bits changed");
  mmw_flags_a: assert property (
    mmw_done |-> STATUS_WORD[15:14] == 2'b00 && STATUS_WORD[12:11] == 2'b00)
    else $error("wide multiply flags not cleared");
  mmw_words_a: assert property (
    mmw_done |-> DEC_DST_WORDS == `FIDST_MMW_WORDS && !DEC_ACC_WRITE)
    else $error("wide multiply store wrong");
  cmp_clear_a: assert property (
    DEC_VALID && DEC_OP == `FIDST_OP_CMP |-> !DEC_ACC_WRITE
    && STATUS_WORD[12:11] == 2'b00) else $error("compare wrong");
  zero_flag_a: assert property (
    DEC_VALID && DEC_OP != `FIDST_OP_MMW |-> STATUS_WORD[15] != STATUS_WORD[13])
    else $error("nonzero and zero flags agree");
  src_inc_a: assert property (
    DEC_VALID && DEC_SRC_KIND == `FIDST_K_AUTO |-> DEC_SRC_REG != 4'h0
    && DEC_SRC_INC == `FIDST_INC_NORM) else $error("source step wrong");
  dst_inc_a: assert property (
    DEC_VALID && DEC_DST_KIND == `FIDST_K_AUTO |-> DEC_DST_INC == (DEC_OP ==
    `FIDST_OP_MMW ? `FIDST_INC_WIDE : `FIDST_INC_NORM)) else $error("dst step");
  acc_group_a: assert property (
    DEC_VALID && DEC_OP <= `FIDST_OP_E2R |-> DEC_ACC_WRITE
    && DEC_SRC_KIND == `FIDST_K_REG) else $error("accumulator op wrong");
endmodule

bind fidst_top fidst_chk #(.AW(AW)) u_chk (
  .REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DEC_VALID(DEC_VALID), .DEC_OP(DEC_OP), .DEC_SRC_KIND(DEC_SRC_KIND),
  .DEC_SRC_REG(DEC_SRC_REG), .DEC_SRC_INC(DEC_SRC_INC),
  .DEC_DST_KIND(DEC_DST_KIND), .DEC_DST_INC(DEC_DST_INC),
  .DEC_ACC_WRITE(DEC_ACC_WRITE), .DEC_DST_WORDS(DEC_DST_WORDS),
  .STATUS_WORD(STATUS_WORD)
);

/* File: bench/float_instr_decode_status_tb.sv */
`timescale 1ns/100ps

module float_instr_decode_status_tb;
  reg         clk;
  reg         rst;
  reg  [5:0]  adr;
  reg         rd;
  reg         wr;
  reg  [31:0] wdat;
  reg  [3:0]  be;
  wire [31:0] rdat;
  wire        wreq;
  wire        irq;
  wire        dv;
  wire [30:0] dec;
  wire [15:0] stw;
  integer     errors;
  integer     check_count;
  integer     seed;
  integer     cyc;
  integer     p;
  integer     t;
  reg  [31:0] q;
  reg  [2:0]  mask;
  reg  [15:0] i0;
  reg  [15:0] i1;
  reg  [31:0] sw;

  fidst_top #(.AW(6)) u_dut (
    .REF_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .IRQ(irq),
    .DEC_VALID(dv), .DEC_OP(dec[30:27]), .DEC_SRC_KIND(dec[26:24]),
    .DEC_SRC_REG(dec[23:20]), .DEC_SRC_INC(dec[19:16]),
    .DEC_DST_KIND(dec[15:13]), .DEC_DST_REG(dec[12:9]),
    .DEC_DST_INC(dec[8:5]), .DEC_ACC_WRITE(dec[4]),
    .DEC_SRC_STORE(dec[3]), .DEC_DST_WORDS(dec[2:0]), .STATUS_WORD(stw)
  );

  // free-running 100 mhz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task complete_run;
    begin
      if (errors == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // one access; idle edge first so strobes never toggle twice at once
  task bus(input w, input [5:0] a, input [31:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      while (wreq) @(posedge clk);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  // model: op id from the first word, 0 when not a float op
  function [3:0] m_op(input [15:0] w);
    begin
      m_op = 4'h0;
      if ((w & 16'hfff9) == 16'h0c00)
        m_op = 4'h1 + {2'b00, w[2:1]};
      else if (w[15:4] == 12'h030 && (w[3:0] == 4'h1 || w[3:0] == 4'h2))
        m_op = w[3:0] + 4'h4;
      else if (w[15:12] == 4'h0)
        case (w[11:6])
          6'h31: m_op = 4'h7;
          6'h32: m_op = 4'hd;
          6'h33, 6'h34, 6'h35, 6'h36, 6'h37: m_op = w[9:6] + 4'h5;
          default: m_op = 4'h0;
        endcase
    end
  endfunction

  function [2:0] m_kind(input [1:0] md, input [3:0] r);
    begin
      if (md == 2'h2)
        m_kind = (r == 4'h0) ? 3'h2 : 3'h3;
      else
        m_kind = (md == 2'h3) ? 3'h4 : {1'b0, md};
    end
  endfunction

  // program one instruction, fire it, compare with the model
  task exec(input [15:0] w0, input [15:0] w1, input [31:0] res,
            input [31:0] ext, input [4:0] cond);
    reg [3:0]  op;
    reg        dual;
    reg        ok;
    reg [1:0]  sm;
    reg [1:0]  dm;
    reg [3:0]  sr;
    reg [3:0]  dr;
    reg [15:0] st0;
    reg [15:0] st;
    reg [30:0] ex;
    integer    k;
    begin
      bus(1'b1, 6'h00, {16'h0, w0});
      bus(1'b1, 6'h04, {16'h0, w1});
      bus(1'b1, 6'h08, res);
      bus(1'b1, 6'h0c, ext);
      bus(1'b1, 6'h10, {27'h0, cond});
      st0 = stw;
      st = st0;
      op = m_op(w0);
      if ((op == 4'h5 || op == 4'h6) && w1[15:12] != 4'h0)
        op = 4'h0;
      dual = op == 4'h5 || op == 4'h6;
      sm = dual ? w1[5:4] : (op >= 4'h7 ? w0[5:4] : 2'h0);
      sr = dual ? w1[3:0] : (op >= 4'h7 ? w0[3:0] : 4'h0);
      dm = dual ? w1[11:10] : 2'h0;
      dr = dual ? w1[9:6] : 4'h0;
      ok = op != 0 && !(sm == 3 && sr == 0) && !(dm == 3 && dr == 0);
      k = op == 0 ? 1 : (ok ? 0 : 2);
      if (op == 4'h6)
        st[15:11] = {2'b00, {ext, res} == 64'h0, 2'b00};
      else if (op == 4'h5)
        st[15:11] = {~cond[4], cond[3], cond[4], 2'b00};
      else begin
        st[15:13] = {res != 0, ~res[31] && res != 0, res == 0};
        if (op == 4'h1 || op == 4'h3)
          st[12:11] = {2{cond[2]}};
        else if (op == 4'h4 || op == 4'hd)
          st[12:11] = 2'b10;
        else if (op >= 4'h7 && op <= 4'ha)
          st[12:11] = {cond[0], cond[0] | cond[1]};
      end
      ex = {op, m_kind(sm, sr), sr, sm == 2'h3 ? 4'h4 : 4'h0, m_kind(dm, dr),
            dr, dm == 2'h3 ? (op == 4'h6 ? 4'h8 : 4'h4) : 4'h0,
            op != 4'h5 && op != 4'h6 && op != 4'hc, op == 4'hc,
            op == 4'h6 ? 3'h4 : 3'h0};
      bus(1'b1, 6'h14, 32'h1);
      @(negedge clk);
      chk(dv, ok);
      chk(irq, mask[k]);
      chk(stw, ok ? st : st0);
      if (ok)
        chk(ex, dec);
      bus(1'b0, 6'h20, 32'h0);
      chk(q[k], 1'b1);
      bus(1'b1, 6'h20, 32'h7);
      @(negedge clk);
      chk(irq, 1'b0);
    end
  endtask

  // hang guard, about ten times the expected two thousand or so cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      complete_run;
    end
  end

  // reset, reset values, then every op class under four masks
  initial begin
    rst = 1'b1;
    adr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    be = 4'hf;
    errors = 0;
    check_count = 0;
    seed = 22;
    cyc = 0;
    mask = 3'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk(stw, 16'h0000);
    bus(1'b1, 6'h3c, 32'hffffffff);
    bus(1'b0, 6'h3c, 32'h0);
    chk(q, 32'h0);
    for (t = 0; t < 10; t = t + 1) begin
      bus(1'b0, {t[3:0], 2'b00}, 32'h0);
      chk(q, t == 7 ? 32'h0000_00c0 : 32'h0);
    end
    for (p = 0; p < 4; p = p + 1) begin
      mask = p == 0 ? 3'h0 : (p == 1 ? 3'h7 : (p == 2 ? 3'h1 : 3'h6));
      bus(1'b1, 6'h24, {29'h0, mask});
      bus(1'b0, 6'h24, 32'h0);
      chk(q[2:0], mask);
      for (t = 0; t < 15; t = t + 1) begin
        sw = $random(seed);
        bus(1'b1, 6'h18, sw);
        bus(1'b0, 6'h18, 32'h0);
        chk(q[15:0], sw[15:0]);
        i1 = $random(seed);
        if (p == 1)
          i1 = i1 & 16'h0c30;
        case (t)
          0, 1, 2, 3: i0 = {13'h0180, t[1:0], 1'b0};
          4, 5: i0 = {12'h030, t[3:0] - 4'h3};
          13: i0 = p[0] ? 16'h0c01 : 16'h0303;
          14: i0 = $random(seed);
          default: i0 = {4'h0, 6'h2b + t[5:0], i1[5:0]};
        endcase
        exec(i0, i1, p == 0 ? 32'h0 : $random(seed),
             p == 0 ? 32'h0 : $random(seed), $random(seed));
      end
    end
    complete_run;
  end
endmodule
